// *** verilog/sdram_cmd_regs.svh ***
`ifndef SDRAM_CMD_REGS_SVH
`define SDRAM_CMD_REGS_SVH

// Clock period of clk in picoseconds (40 MHz)
`define CLK_PERIOD_PS 25000

// Bank timing in nanoseconds
`define PRECHARGE_PERIOD_NS 20
`define ROW_TO_COLUMN_DELAY_NS 20
`define ROW_CYCLE_PERIOD_NS 70

// Timing in clocks
`define WRITE_RECOVERY_CLK 2
`define MODE_ACCESS_CLK 2

// Least time in ns rounded up to whole clocks
`define CYCLES_MIN(ns) ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PRECHARGE_PERIOD_CYC `CYCLES_MIN(`PRECHARGE_PERIOD_NS)
`define ROW_TO_COLUMN_DELAY_CYC `CYCLES_MIN(`ROW_TO_COLUMN_DELAY_NS)
`define ROW_CYCLE_PERIOD_CYC `CYCLES_MIN(`ROW_CYCLE_PERIOD_NS)

// Address fields
`define AUTO_PRECHARGE_BIT 10
`define BURST_LEN_MSB 2
`define BURST_LEN_LSB 0
`define COLUMN_MSB 9
`define BURST_FULL_PAGE 3'h7

// Reset values
`define MODE_VALUE_RESET 13'h0000

`endif

// *** verilog/sdram_cmd_pkg.sv ***
package sdram_cmd_pkg;

  // Per-bank state, one-hot
  typedef enum logic [7:0] {
    BANK_IDLE = 8'h01,
    BANK_ACTIVATING = 8'h02,
    BANK_ACTIVE = 8'h04,
    BANK_READ = 8'h08,
    BANK_WRITE = 8'h10,
    BANK_READ_AP = 8'h20,
    BANK_WRITE_AP = 8'h40,
    BANK_PRECHARGING = 8'h80
  } bank_state_type;

  // Device-wide state, one-hot
  typedef enum logic [3:0] {
    DEV_NORMAL = 4'h1,
    DEV_REFRESHING = 4'h2,
    DEV_MODE_ACCESS = 4'h4,
    DEV_SELF_REFRESH = 4'h8
  } dev_state_type;

  // Decoded command
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_BURST_STOP = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_ACTIVATE = 3'h4,
    CMD_PRECHARGE = 3'h5,
    CMD_REFRESH = 3'h6,
    CMD_MODE = 3'h7
  } cmd_type;

endpackage

// *** verilog/sdram_bank_fsm.sv ***
// Summary of operation
// - Decode only when clock enable high twice, except refresh with clock enable falling
// - Activate on idle bank latches row
// - Refresh from idle, nop returns after cycle
// - Refresh and mode need all banks idle
// - Illegality judged per addressed bank state, burst stop against every bank state
// - Precharge to idle bank is nop
// - Precharge closes active bank, A10 all
// - Read or write starts burst, samples flag
// - Activating bank rejects commands until delay
// - Burst runs out, back to active
// - Burst stop ends burst, stays active
// - New read or write restarts burst
// - Precharge during read uses read timing
// - Precharge during write adds write recovery
// - Auto precharge burst rejects interrupting commands
// - Mode access idles after two nop clocks
// - Clock enable low on refresh: self refresh
`timescale 1ns/1ps
`include "sdram_cmd_regs.svh"

module sdram_bank_fsm (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  // Tracked state
  output sdram_cmd_pkg::bank_state_type bank_state [4],
  output sdram_cmd_pkg::dev_state_type dev_state,
  output logic [12:0] row_addr_value [4],
  output logic [9:0] column_addr_value [4],
  output logic [3:0] auto_precharge_flag,
  output logic [12:0] mode_value,
  output logic illegal_cmd
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Strobe decode; deselect counts as nop
  function automatic sdram_cmd_pkg::cmd_type decode_cmd(input logic cs,
      input logic ras, input logic cas, input logic we);
    sdram_cmd_pkg::cmd_type c;
    c = sdram_cmd_pkg::CMD_NOP;
    if (!cs) begin
      unique case ({ras, cas, we})
        3'h7: c = sdram_cmd_pkg::CMD_NOP;
        3'h6: c = sdram_cmd_pkg::CMD_BURST_STOP;
        3'h5: c = sdram_cmd_pkg::CMD_READ;
        3'h4: c = sdram_cmd_pkg::CMD_WRITE;
        3'h3: c = sdram_cmd_pkg::CMD_ACTIVATE;
        3'h2: c = sdram_cmd_pkg::CMD_PRECHARGE;
        3'h1: c = sdram_cmd_pkg::CMD_REFRESH;
        3'h0: c = sdram_cmd_pkg::CMD_MODE;
      endcase
    end
    return c;
  endfunction

  // Beats left after the first, from the burst length code
  function automatic logic [3:0] burst_beats(input logic [2:0] code);
    logic [3:0] n;
    unique case (code)
      3'h0: n = 4'h0;
      3'h1: n = 4'h1;
      3'h2: n = 4'h3;
      3'h3: n = 4'h7;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

  // Counter step toward zero
  function automatic logic [3:0] step_down(input logic [3:0] v);
    return (v == 4'h0) ? 4'h0 : 4'(v - 4'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timing loads (count minus one, the command cycle itself counts)

  localparam logic [3:0] RCD_LOAD = 4'(`ROW_TO_COLUMN_DELAY_CYC - 1);
  localparam logic [3:0] RP_LOAD = 4'(`PRECHARGE_PERIOD_CYC - 1);
  localparam logic [3:0] WRP_LOAD = 4'(`WRITE_RECOVERY_CLK + `PRECHARGE_PERIOD_CYC - 1);
  localparam logic [3:0] RC_LOAD = 4'(`ROW_CYCLE_PERIOD_CYC - 1);
  localparam logic [3:0] MA_LOAD = 4'(`MODE_ACCESS_CLK - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sdram_cmd_pkg::bank_state_type bank_state_reg [4];
  sdram_cmd_pkg::bank_state_type bank_state_next [4];
  logic [3:0] timer_reg [4];
  logic [3:0] timer_next [4];
  logic [3:0] burst_reg [4];
  logic [3:0] burst_next [4];
  logic [12:0] row_reg [4];
  logic [12:0] row_next [4];
  logic [9:0] col_reg [4];
  logic [9:0] col_next [4];
  logic [3:0] ap_reg;
  logic [3:0] ap_next;
  sdram_cmd_pkg::dev_state_type dev_state_reg;
  sdram_cmd_pkg::dev_state_type dev_state_next;
  logic [3:0] dev_timer_reg;
  logic [3:0] dev_timer_next;
  logic [12:0] mode_reg;
  logic [12:0] mode_next;
  logic cke_prev_reg;
  logic illegal_reg;
  logic illegal_next;

  sdram_cmd_pkg::cmd_type cmd;
  logic cke_ok;
  logic all_idle;
  logic full_page;

  ////////////////////////////////////////////////////////////////////////////
  // Command qualification

  assign cmd = decode_cmd(cs_n, ras_n, cas_n, we_n);
  assign cke_ok = cke_prev_reg & cke;
  assign full_page = (mode_reg[`BURST_LEN_MSB:`BURST_LEN_LSB] == `BURST_FULL_PAGE);
  assign all_idle = (bank_state_reg[0] == sdram_cmd_pkg::BANK_IDLE) &&
                    (bank_state_reg[1] == sdram_cmd_pkg::BANK_IDLE) &&
                    (bank_state_reg[2] == sdram_cmd_pkg::BANK_IDLE) &&
                    (bank_state_reg[3] == sdram_cmd_pkg::BANK_IDLE) &&
                    (dev_state_reg == sdram_cmd_pkg::DEV_NORMAL);

  ////////////////////////////////////////////////////////////////////////////
  // Next state of banks and device

  always_comb begin
    logic sel;
    logic hit;
    logic bank_ill;
    logic last;
    sel = 1'b0;
    hit = 1'b0;
    bank_ill = 1'b0;
    last = 1'b0;
    bank_state_next = bank_state_reg;
    timer_next = timer_reg;
    burst_next = burst_reg;
    row_next = row_reg;
    col_next = col_reg;
    ap_next = ap_reg;
    dev_state_next = dev_state_reg;
    dev_timer_next = dev_timer_reg;
    mode_next = mode_reg;
    illegal_next = 1'b0;
    // Banks move only in normal operation with clock enable held
    if (cke_ok && dev_state_reg == sdram_cmd_pkg::DEV_NORMAL) begin
      for (int b = 0; b < 4; b++) begin
        sel = (ba == 2'(b));
        hit = sel | (cmd == sdram_cmd_pkg::CMD_PRECHARGE && addr[`AUTO_PRECHARGE_BIT]);
        last = (burst_reg[b] == 4'h0) && !full_page;
        unique case (bank_state_reg[b])
          sdram_cmd_pkg::BANK_IDLE: begin
            if (sel && cmd == sdram_cmd_pkg::CMD_ACTIVATE) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_ACTIVATING;
              row_next[b] = addr;
              timer_next[b] = RCD_LOAD;
            end else if (sel && (cmd == sdram_cmd_pkg::CMD_READ ||
                cmd == sdram_cmd_pkg::CMD_WRITE)) begin
              bank_ill = 1'b1;
            end
            // Burst stop with nothing running is rejected
            if (cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
              bank_ill = 1'b1;
            end
          end
          sdram_cmd_pkg::BANK_ACTIVATING: begin
            if ((hit && cmd != sdram_cmd_pkg::CMD_REFRESH && cmd != sdram_cmd_pkg::CMD_MODE
                && cmd != sdram_cmd_pkg::CMD_NOP) || cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
              bank_ill = 1'b1;
            end
            if (timer_reg[b] == 4'h0) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_ACTIVE;
            end else begin
              timer_next[b] = step_down(timer_reg[b]);
            end
          end
          sdram_cmd_pkg::BANK_ACTIVE: begin
            if (sel && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE)) begin
              bank_state_next[b] = (cmd == sdram_cmd_pkg::CMD_READ) ?
                  sdram_cmd_pkg::BANK_READ : sdram_cmd_pkg::BANK_WRITE;
              col_next[b] = addr[`COLUMN_MSB:0];
              ap_next[b] = addr[`AUTO_PRECHARGE_BIT];
              burst_next[b] = burst_beats(mode_reg[`BURST_LEN_MSB:`BURST_LEN_LSB]);
              if (addr[`AUTO_PRECHARGE_BIT]) begin
                bank_state_next[b] = (cmd == sdram_cmd_pkg::CMD_READ) ?
                    sdram_cmd_pkg::BANK_READ_AP : sdram_cmd_pkg::BANK_WRITE_AP;
              end
            end else if (hit && cmd == sdram_cmd_pkg::CMD_PRECHARGE) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_PRECHARGING;
              timer_next[b] = RP_LOAD;
            end else if ((sel && cmd == sdram_cmd_pkg::CMD_ACTIVATE) ||
                cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
              bank_ill = 1'b1;
            end
          end
          sdram_cmd_pkg::BANK_READ, sdram_cmd_pkg::BANK_WRITE: begin
            // Controller spaces read/write turnaround and write recovery
            if (sel && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE)) begin
              bank_state_next[b] = (cmd == sdram_cmd_pkg::CMD_READ) ?
                  sdram_cmd_pkg::BANK_READ : sdram_cmd_pkg::BANK_WRITE;
              col_next[b] = addr[`COLUMN_MSB:0];
              ap_next[b] = addr[`AUTO_PRECHARGE_BIT];
              burst_next[b] = burst_beats(mode_reg[`BURST_LEN_MSB:`BURST_LEN_LSB]);
              if (addr[`AUTO_PRECHARGE_BIT]) begin
                bank_state_next[b] = (cmd == sdram_cmd_pkg::CMD_READ) ?
                    sdram_cmd_pkg::BANK_READ_AP : sdram_cmd_pkg::BANK_WRITE_AP;
              end
            end else if (hit && cmd == sdram_cmd_pkg::CMD_PRECHARGE) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_PRECHARGING;
              timer_next[b] = (bank_state_reg[b] == sdram_cmd_pkg::BANK_READ) ?
                  RP_LOAD : WRP_LOAD;
            end else if (cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_ACTIVE;
            end else if (sel && cmd == sdram_cmd_pkg::CMD_ACTIVATE) begin
              bank_ill = 1'b1;
            end else if (last) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_ACTIVE;
            end else begin
              burst_next[b] = step_down(burst_reg[b]);
            end
          end
          sdram_cmd_pkg::BANK_READ_AP, sdram_cmd_pkg::BANK_WRITE_AP: begin
            if ((sel && cmd != sdram_cmd_pkg::CMD_NOP && cmd != sdram_cmd_pkg::CMD_REFRESH &&
                cmd != sdram_cmd_pkg::CMD_MODE) || (hit && cmd == sdram_cmd_pkg::CMD_PRECHARGE)
                || cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
              bank_ill = 1'b1;
            end
            if (last) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_PRECHARGING;
              timer_next[b] = (bank_state_reg[b] == sdram_cmd_pkg::BANK_READ_AP) ?
                  RP_LOAD : WRP_LOAD;
            end else begin
              burst_next[b] = step_down(burst_reg[b]);
            end
          end
          sdram_cmd_pkg::BANK_PRECHARGING: begin
            if ((sel && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE ||
                cmd == sdram_cmd_pkg::CMD_ACTIVATE)) || cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
              bank_ill = 1'b1;
            end
            // A repeated precharge does not restart the period
            if (timer_reg[b] == 4'h0) begin
              bank_state_next[b] = sdram_cmd_pkg::BANK_IDLE;
            end else begin
              timer_next[b] = step_down(timer_reg[b]);
            end
          end
        endcase
      end
    end
    // Device-wide refresh, mode access and self refresh
    unique case (dev_state_reg)
      sdram_cmd_pkg::DEV_NORMAL: begin
        if (cmd == sdram_cmd_pkg::CMD_REFRESH || cmd == sdram_cmd_pkg::CMD_MODE) begin
          if (cke_prev_reg && !all_idle) begin
            illegal_next = 1'b1;
          end else if (cke_ok && cmd == sdram_cmd_pkg::CMD_REFRESH) begin
            dev_state_next = sdram_cmd_pkg::DEV_REFRESHING;
            dev_timer_next = RC_LOAD;
          end else if (cke_prev_reg && cmd == sdram_cmd_pkg::CMD_REFRESH) begin
            dev_state_next = sdram_cmd_pkg::DEV_SELF_REFRESH;
          end else if (cke_ok) begin
            dev_state_next = sdram_cmd_pkg::DEV_MODE_ACCESS;
            dev_timer_next = MA_LOAD;
            mode_next = addr;
          end
        end
      end
      sdram_cmd_pkg::DEV_REFRESHING, sdram_cmd_pkg::DEV_MODE_ACCESS: begin
        if (cke_ok) begin
          // Burst stop strobes count as a nop while refreshing
          if (cmd != sdram_cmd_pkg::CMD_NOP && !(cmd == sdram_cmd_pkg::CMD_BURST_STOP &&
              dev_state_reg == sdram_cmd_pkg::DEV_REFRESHING)) begin
            illegal_next = 1'b1;
          end
          if (dev_timer_reg == 4'h0) begin
            dev_state_next = sdram_cmd_pkg::DEV_NORMAL;
          end else begin
            dev_timer_next = step_down(dev_timer_reg);
          end
        end
      end
      sdram_cmd_pkg::DEV_SELF_REFRESH: begin
        // Exit waits one row cycle like a refresh
        if (!cke_prev_reg && cke) begin
          dev_state_next = sdram_cmd_pkg::DEV_REFRESHING;
          dev_timer_next = RC_LOAD;
        end
      end
    endcase
    if (bank_ill) begin
      illegal_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int b = 0; b < 4; b++) begin
        bank_state_reg[b] <= sdram_cmd_pkg::BANK_IDLE;
        timer_reg[b] <= 4'h0;
        burst_reg[b] <= 4'h0;
        row_reg[b] <= 13'h0000;
        col_reg[b] <= 10'h000;
      end
      ap_reg <= 4'h0;
      dev_state_reg <= sdram_cmd_pkg::DEV_NORMAL;
      dev_timer_reg <= 4'h0;
      mode_reg <= `MODE_VALUE_RESET;
      cke_prev_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      bank_state_reg <= bank_state_next;
      timer_reg <= timer_next;
      burst_reg <= burst_next;
      row_reg <= row_next;
      col_reg <= col_next;
      ap_reg <= ap_next;
      dev_state_reg <= dev_state_next;
      dev_timer_reg <= dev_timer_next;
      mode_reg <= mode_next;
      cke_prev_reg <= cke;
      illegal_reg <= illegal_next;
    end
  end

  // Outputs straight from the registers
  assign bank_state = bank_state_reg;
  assign dev_state = dev_state_reg;
  assign row_addr_value = row_reg;
  assign column_addr_value = col_reg;
  assign auto_precharge_flag = ap_reg;
  assign mode_value = mode_reg;
  assign illegal_cmd = illegal_reg;

endmodule // sdram_bank_fsm

// *** test/sdram_bank_fsm_asserts.sv ***
`timescale 1ns/1ps
// Watches the command pins against the state that bank 0 and the device report
module sdram_bank_fsm_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  // Tracked state
  input sdram_cmd_pkg::bank_state_type bank_state [4],
  input sdram_cmd_pkg::dev_state_type dev_state,
  input logic [12:0] row_addr_value [4],
  input logic [9:0] column_addr_value [4],
  input logic [3:0] auto_precharge_flag,
  input logic [12:0] mode_value,
  input logic illegal_cmd
);
  logic cke_reg;
  logic cke_next;
  logic [3:0] op;
  logic [7:0] s0;
  logic [3:0] dv;
  logic ap;
  logic [9:0] col;
  logic idle_all;
  // Clock enable of the previous edge, cleared by reset
  always_comb cke_next = rstn ? cke : 1'b0;
  always_ff @(posedge clk) cke_reg <= cke_next;
  // Decoded command: 8 mode, 9 refresh, A precharge, B activate, C write, D read, E stop
  assign op = {cke && cke_reg && !cs_n, ras_n, cas_n, we_n};
  assign s0 = (ba == 2'h0) || (op == 4'hE) ? bank_state[0] : 8'h00;
  assign dv = dev_state;
  assign ap = addr[10];
  assign col = addr[9:0];
  assign idle_all = (bank_state[0] & bank_state[1] & bank_state[2] & bank_state[3]) == 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_mode_hold;
    dv == 4'h4 && mode_value == $past(addr) ##1 dv == 4'h4 ##1 dv == 4'h1;
  endsequence
  sequence s_close;
    bank_state[0] == 8'h80 ##1 bank_state[0] == 8'h01;
  endsequence
  property p_act;
    op == 4'hB && s0 == 8'h01 && dv == 4'h1
      |=> bank_state[0] == 8'h02 && row_addr_value[0] == $past(addr);
  endproperty
  a_act: assert property (p_act) else $error("activate did not open bank 0");
  property p_busy;
    (op == 4'h8 || op == 4'h9) && bank_state[0] != 8'h01 |=> illegal_cmd;
  endproperty
  a_busy: assert property (p_busy) else $error("refresh or mode not refused");
  property p_pre_idle;
    op == 4'hA && s0 == 8'h01 && dv == 4'h1 |=> bank_state[0] == 8'h01 && !illegal_cmd;
  endproperty
  a_pre_idle: assert property (p_pre_idle) else $error("precharge of idle bank acted");
  property p_pre;
    op == 4'hA && s0 == 8'h04 |=> s_close;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge did not close bank 0");
  property p_rd;
    op == 4'hD && s0 == 8'h04 |=> column_addr_value[0] == $past(col)
      && auto_precharge_flag[0] == $past(ap) && bank_state[0] == ($past(ap) ? 8'h20 : 8'h08);
  endproperty
  a_rd: assert property (p_rd) else $error("read did not start burst");
  property p_stop;
    op == 4'hE && (s0 == 8'h08 || s0 == 8'h10) |=> bank_state[0] == 8'h04;
  endproperty
  a_stop: assert property (p_stop) else $error("burst stop did not return to active");
  property p_ap;
    op == 4'hE && s0 == 8'h20 |=> illegal_cmd;
  endproperty
  a_ap: assert property (p_ap) else $error("stop of auto precharge burst not refused");
  property p_mode;
    op == 4'h8 && idle_all && dv == 4'h1 |=> s_mode_hold;
  endproperty
  a_mode: assert property (p_mode) else $error("mode access timing wrong");
  property p_mode_ill;
    dv == 4'h4 && op[3] && op != 4'hF |=> illegal_cmd;
  endproperty
  a_mode_ill: assert property (p_mode_ill) else $error("command in mode access not refused");
  property p_ref_ill;
    dv == 4'h2 && op[3] && !(ras_n && cas_n) |=> illegal_cmd;
  endproperty
  a_ref_ill: assert property (p_ref_ill) else $error("command in refresh not refused");
endmodule // sdram_bank_fsm_chk
bind sdram_bank_fsm sdram_bank_fsm_chk u_chk (.clk(clk), .rstn(rstn), .cke(cke), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .bank_state(bank_state),
  .dev_state(dev_state), .row_addr_value(row_addr_value), .column_addr_value(column_addr_value),
  .auto_precharge_flag(auto_precharge_flag), .mode_value(mode_value), .illegal_cmd(illegal_cmd));

// *** test/sdram_ctrl_model.sv ***
`timescale 1ns/1ps
// Controller side: turns a requested command into strobes, junk on idle lines
module sdram_ctrl_model (
  // Clock
  input wire logic clk,
  // Request from the sequence
  input wire logic [2:0] req_cmd,
  input wire logic [1:0] req_ba,
  input wire logic [12:0] req_addr,
  input wire logic req_cke,
  // Memory pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr
);
  logic [12:0] junk = 13'h0AAA;
  // Lines not qualified by a command change every cycle
  always @(negedge clk) junk <= ~junk;
  // Strobe encoding; code 0 is a deselect
  always_comb begin
    cke = req_cke;
    case (req_cmd)
      3'h0: {cs_n, ras_n, cas_n, we_n} = {1'b1, junk[2:0]};
      3'h1: {cs_n, ras_n, cas_n, we_n} = 4'h6;
      3'h2: {cs_n, ras_n, cas_n, we_n} = 4'h5;
      3'h3: {cs_n, ras_n, cas_n, we_n} = 4'h4;
      3'h4: {cs_n, ras_n, cas_n, we_n} = 4'h3;
      3'h5: {cs_n, ras_n, cas_n, we_n} = 4'h2;
      3'h6: {cs_n, ras_n, cas_n, we_n} = 4'h1;
      default: {cs_n, ras_n, cas_n, we_n} = 4'h0;
    endcase
    ba = (req_cmd == 3'h0) ? junk[4:3] : req_ba;
    addr = (req_cmd == 3'h0) ? junk : req_addr;
  end
endmodule // sdram_ctrl_model

// *** test/sdram_bank_command_state_machine_tb.sv ***
`timescale 1ns/1ps
// Commands: 0 nop, 1 stop, 2 read, 3 write, 4 activate, 5 precharge, 6 refresh, 7 mode
module sdram_bank_command_state_machine_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] req_cmd = 3'h0;
  logic [1:0] req_ba = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic req_cke = 1'b1;
  logic cke_want = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  sdram_cmd_pkg::bank_state_type bank_state [4];
  sdram_cmd_pkg::dev_state_type dev_state;
  logic [12:0] row_addr_value [4];
  logic [9:0] column_addr_value [4];
  logic [3:0] auto_precharge_flag;
  logic [12:0] mode_value;
  logic illegal_cmd;
  logic [7:0] exp_st [4] = '{8'h01, 8'h01, 8'h01, 8'h01};
  int exp_cnt [4];
  logic [12:0] rows [$];
  logic cke_m = 1'b0;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 32'h0c39;
  int k;
  logic [12:0] r;
  always #12.5 clk = ~clk;
  sdram_ctrl_model ctrl (.clk(clk), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
    .req_cke(req_cke), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr));
  sdram_bank_fsm uut (.clk(clk), .rstn(rstn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .bank_state(bank_state),
    .dev_state(dev_state), .row_addr_value(row_addr_value), .column_addr_value(column_addr_value),
    .auto_precharge_flag(auto_precharge_flag), .mode_value(mode_value), .illegal_cmd(illegal_cmd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // Reference bank states, burst length one, write precharge three clocks
  task automatic model(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    logic hit;
    logic [7:0] s;
    for (int i = 0; i < 4; i++) begin
      s = exp_st[i];
      hit = (c != 3'h0) && (b == 2'(i) || (c == 3'h5 && a[10]));
      case (s)
        8'h01: if (hit && c == 3'h4) s = 8'h02;
        8'h02: s = 8'h04;
        8'h04, 8'h08, 8'h10: begin
          if (hit && c inside {3'h2, 3'h3}) s = 8'h08 << {a[10], c[0]};
          else if (hit && c == 3'h5) begin
            exp_cnt[i] = (s == 8'h10) ? 3 : 1;
            s = 8'h80;
          end else s = 8'h04;
        end
        8'h20: begin
          exp_cnt[i] = 1;
          s = 8'h80;
        end
        default: begin
          exp_cnt[i]--;
          if (exp_cnt[i] == 0) s = 8'h01;
        end
      endcase
      exp_st[i] = s;
    end
  endtask
  // One command at one edge; ei 2 leaves the illegal flag unchecked
  task automatic step(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a, input int ei);
    @(negedge clk);
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    req_cke = cke_want;
    @(posedge clk);
    if (req_cke && cke_m) model(c, b, a);
    cke_m = req_cke;
    #1;
    for (int i = 0; i < 4; i++) check("bank state", exp_st[i], bank_state[i]);
    if (ei < 2) check("illegal flag", 13'(ei), illegal_cmd);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    step(3'h0, 2'h0, 13'h0000, 0);
    check("dev state", 13'h0001, dev_state);
    check("mode value", 13'h0000, mode_value);
    r = 13'($random(seed)) & 13'h1FF8;
    step(3'h7, 2'h0, r, 0);
    check("mode value", r, mode_value);
    step(3'h2, 2'h1, 13'h0000, 1);
    check("dev state", 13'h0004, dev_state);
    step(3'h0, 2'h0, 13'h0000, 0);
    check("dev state", 13'h0001, dev_state);
    step(3'h0, 2'h0, 13'h0000, 0);
    step(3'h5, 2'h0, 13'h0000, 0);
    $display("mode and idle precharge test done");
    for (k = 0; k < 4; k++) begin
      r = 13'($random(seed));
      rows.push_back(r);
      step(3'h4, 2'(k), r, 0);
    end
    step(3'h4, 2'h3, 13'h0000, 1);
    for (k = 0; k < 4; k++) check("row", rows[k], row_addr_value[k]);
    step(3'h6, 2'h0, 13'h0000, 1);
    step(3'h7, 2'h0, 13'h0000, 1);
    $display("activate test done");
    r = 13'($random(seed)) & 13'h03FF;
    step(3'h2, 2'h0, r, 0);
    check("column", r, 13'(column_addr_value[0]));
    step(3'h0, 2'h0, 13'h0000, 0);
    step(3'h3, 2'h0, r, 0);
    step(3'h1, 2'h2, 13'h0000, 2);
    step(3'h3, 2'h1, r, 0);
    step(3'h2, 2'h1, r ^ 13'h0001, 0);
    check("column", r ^ 13'h0001, 13'(column_addr_value[1]));
    step(3'h5, 2'h1, 13'h0000, 0);
    step(3'h3, 2'h2, 13'h0000, 0);
    step(3'h5, 2'h2, 13'h0000, 0);
    repeat (3) step(3'h0, 2'h0, 13'h0000, 0);
    $display("burst test done");
    step(3'h2, 2'h0, 13'h0400, 0);
    check("auto precharge", 13'h0001, 13'(auto_precharge_flag[0]));
    step(3'h1, 2'h0, 13'h0000, 1);
    step(3'h4, 2'h0, 13'h0000, 2);
    step(3'h4, 2'h0, 13'h0000, 0);
    step(3'h0, 2'h0, 13'h0000, 0);
    step(3'h5, 2'h0, 13'h0400, 0);
    step(3'h0, 2'h0, 13'h0000, 0);
    $display("auto precharge test done");
    step(3'h6, 2'h0, 13'h0000, 0);
    check("dev state", 13'h0002, dev_state);
    step(3'h2, 2'h1, 13'h0000, 1);
    k = 0;
    while (dev_state !== sdram_cmd_pkg::DEV_NORMAL && k < 8) begin
      step(3'h0, 2'h0, 13'h0000, 0);
      k++;
    end
    if (k == 8) begin
      mismatches++;
      end_of_test();
    end
    $display("refresh test done");
    cke_want = 1'b0;
    step(3'h6, 2'h0, 13'h0000, 0);
    check("dev state", 13'h0008, dev_state);
    cke_want = 1'b1;
    step(3'h0, 2'h0, 13'h0000, 0);
    check("dev state", 13'h0002, dev_state);
    k = 0;
    while (dev_state !== sdram_cmd_pkg::DEV_NORMAL && k < 8) begin
      step(3'h0, 2'h0, 13'h0000, 0);
      k++;
    end
    if (k == 8) begin
      mismatches++;
      end_of_test();
    end
    $display("self refresh test done");
    cke_want = 1'b0;
    step(3'h4, 2'h0, 13'h0000, 2);
    cke_want = 1'b1;
    step(3'h4, 2'h0, 13'h0000, 2);
    step(3'h4, 2'h0, 13'h0055, 0);
    check("row", 13'h0055, row_addr_value[0]);
    $display("clock enable test done");
    end_of_test();
  end
endmodule // sdram_bank_command_state_machine_tb
